// file: configurable_shift_register_test.sv
// Self-checking bench of the shift register, pins and register port.
// Assumes the default async-clear, loadable, bidirectional variant.
`timescale 1ns/1ps
`default_nettype none
module configurable_shift_register_test;
   localparam int unsigned W = 8;
   logic         clk_i, rst_i, async_clear_i, sync_reset_i, load_i;
   logic         clk_en_i, shift_left_i, left_serial_in_i, cascade_o;
   logic         right_serial_in_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [W-1:0] data_i, q_o, m, pm;
   logic [7:0]   wb_adr_i;
   logic [3:0]   wb_sel_i;
   logic [31:0]  wb_dat_i, wb_dat_o;
   int           fails, compares;

   csr_shift_top #(.WIDTH(W)) dut (.clk_i, .rst_i, .async_clear_i,
      .sync_reset_i, .load_i, .clk_en_i, .shift_left_i, .left_serial_in_i,
      .right_serial_in_i, .data_i, .q_o, .cascade_o, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
   csr_user_cascade #(.W(W)) partner (.clk_i, .rst_i,
      .clear_i(async_clear_i), .ld_i(load_i), .en_i(clk_en_i),
      .up_i(shift_left_i), .cascade_i(cascade_o), .q_o(pm));

   // Clock at 200 MHz
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One pin operation, then an idle cycle; model follows the rules
   task automatic op(input logic l, e, d, s, r, input logic [W-1:0] dat);
      @(posedge clk_i);
      load_i            <= l;
      clk_en_i          <= e;
      shift_left_i      <= d;
      left_serial_in_i  <= s;
      right_serial_in_i <= r;
      data_i            <= dat;
      @(posedge clk_i);
      load_i   <= 1'b0;
      clk_en_i <= 1'b0;
      #1;
      if (l)
         m = dat;
      else if (e && d)
         m = {m[W-2:0], s};
      else if (e)
         m = {r, m[W-1:1]};
   endtask : op

   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] dt, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= dt;
      // Wait for the answer; only the watchdog ends a hung wait
      do
      begin
         @(posedge clk_i);
      end
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_load_hold;
      op(1, 0, 0, 0, 0, 8'hA5);
      chk("load", q_o, 32'hA5);
      op(1, 1, 1, 1, 1, 8'h3C);
      chk("load_en", q_o, 32'h3C);
      op(0, 0, 1, 1, 1, 8'hFF);
      chk("hold", q_o, 32'h3C);
   endtask : t_load_hold

   task automatic t_shift;
      logic [W-1:0] pre;
      for (int i = 0; i < 2 * W; i++)
      begin
         op(0, 1, 1, i[0] ^ i[2], 0, '0);
         chk("up", q_o, m);
         // Bits pushed out of the top fill the cascaded register
         if (i == W - 1)
            pre = m;
      end
      chk("cascade", pm, pre);
      for (int i = 0; i < W; i++)
      begin
         op(0, 1, 0, 1, i[1], '0);
         chk("down", q_o, m);
      end
   endtask : t_shift

   task automatic t_clear;
      op(1, 0, 0, 0, 0, 8'h5A);
      @(posedge clk_i);
      async_clear_i <= 1'b1;
      load_i        <= 1'b1;
      clk_en_i      <= 1'b1;
      #1;
      chk("clear_now", q_o, 0);
      @(posedge clk_i);
      #1;
      chk("clear_edge", {pm, cascade_o, q_o}, 0);
      @(posedge clk_i);
      async_clear_i <= 1'b0;
      load_i        <= 1'b0;
      clk_en_i      <= 1'b0;
      m = '0;
   endtask : t_clear

   task automatic t_regs;
      logic [31:0] r;
      wb(0, 8'h10, 0, r);
      chk("info", r, W | 32'h0600);
      wb(0, 8'h24, 0, r);
      chk("unmapped", r, 0);
      wb(1, 8'h00, 32'h1, r);
      wb(1, 8'h04, 32'h96, r);
      wb(1, 8'h08, 32'h2, r);
      wb(0, 8'h0C, 0, r);
      chk("stat_load", r, 32'h96);
      wb(1, 8'h00, 32'h7, r);
      wb(1, 8'h08, 32'h1, r);
      wb(0, 8'h0C, 0, r);
      chk("stat_up", r, 32'h2D);
      wb(1, 8'h00, 32'h9, r);
      wb(1, 8'h08, 32'h1, r);
      wb(0, 8'h0C, 0, r);
      chk("stat_down", r, 32'h96);
      wb(1, 8'h00, 32'h0, r);
      m = 8'h96;
   endtask : t_regs

   task automatic t_grst;
      @(posedge clk_i);
      rst_i <= 1'b1;
      #1;
      chk("grst", {cascade_o, q_o}, 0);
      @(posedge clk_i);
      rst_i <= 1'b0;
      m = '0;
   endtask : t_grst

   task automatic close_out;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // Main sequence
   initial
   begin
      rst_i = 1'b0;
      {async_clear_i, sync_reset_i, load_i, clk_en_i, shift_left_i} = '0;
      {left_serial_in_i, right_serial_in_i, wb_cyc_i, wb_stb_i} = '0;
      {wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hF;
      data_i = '0;
      m = '0;
      fails = 0;
      compares = 0;
      // Raise reset after time zero so every clear edge is seen
      #1;
      rst_i = 1'b1;
      #1;
      chk("power_up", q_o, 0);
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_load_hold();
      t_clear();
      t_shift();
      t_regs();
      t_grst();
      op(0, 1, 1, 1, 0, '0);
      chk("after_grst", q_o, 32'h01);
      close_out();
   end

   // Watchdog against a hung handshake
   initial
   begin
      #20000;
      fails++;
      close_out();
   end
endmodule : configurable_shift_register_test

bind csr_shift_top csr_shift_assertions #(.WIDTH(WIDTH)) u_chk (.clk_i,
   .rst_i, .async_clear_i, .load_i, .clk_en_i, .shift_left_i,
   .left_serial_in_i, .right_serial_in_i, .data_i, .q_o, .cascade_o,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_ack_o);
`default_nettype wire

// file: csr_op_sel.sv
// Priority decode of the control inputs into one stage operation.
// Assumes control levels are synchronous to the stage clock.

`timescale 1ns/1ps
`default_nettype none

module csr_op_sel
#(
   parameter csr_pkg::csr_rst_style_t RST_STYLE = csr_pkg::CSR_ASYNC_CLEAR,
   parameter bit                      HAS_LOAD  = 1'b1,
   parameter bit                      HAS_BIDIR = 1'b1
)
(
   input  wire logic             sync_reset_i,
   input  wire logic             load_i,
   input  wire logic             clk_en_i,
   input  wire logic             shift_left_i,
   output var  csr_pkg::csr_op_t op_o
);

   // ----------------------------------------------------------------
   // Priority: reset, load, shift, hold
   // ----------------------------------------------------------------
   always_comb
   begin
      op_o = csr_pkg::CSR_OP_HOLD;
      if ((RST_STYLE == csr_pkg::CSR_SYNC_RESET) && sync_reset_i)
         op_o = csr_pkg::CSR_OP_ZERO;
      else if (HAS_LOAD && load_i)
         op_o = csr_pkg::CSR_OP_LOAD;
      else if (clk_en_i)
      begin
         // Serial-only variants always shift upward
         if (!HAS_BIDIR || shift_left_i)
            op_o = csr_pkg::CSR_OP_UP;
         else
            op_o = csr_pkg::CSR_OP_DOWN;
      end
      else
         op_o = csr_pkg::CSR_OP_HOLD;
   end

endmodule : csr_op_sel

`default_nettype wire

// file: csr_pkg.sv
// Shared constants and types of the configurable shift register.
// Assumes a 32-bit classic Wishbone bus and a 200 MHz system clock.

`default_nettype none

package csr_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned CSR_ADR_W = 8;
   localparam int unsigned CSR_DAT_W = 32;
   localparam int unsigned CSR_SEL_W = 4;
   localparam int unsigned CSR_MAX_W = 16;   // Widest legal register

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CSR_OFF_CTRL = 8'h00;
   localparam logic [7:0] CSR_OFF_DATA = 8'h04;
   localparam logic [7:0] CSR_OFF_CMD  = 8'h08;
   localparam logic [7:0] CSR_OFF_STAT = 8'h0C;
   localparam logic [7:0] CSR_OFF_INFO = 8'h10;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int unsigned CSR_CTRL_W     = 5;
   localparam int unsigned CSR_CTRL_SW    = 0;  // Software drives controls
   localparam int unsigned CSR_CTRL_LEFT  = 1;  // Shift direction, 1 = up
   localparam int unsigned CSR_CTRL_SLI   = 2;  // Left serial input level
   localparam int unsigned CSR_CTRL_SRI   = 3;  // Right serial input level
   localparam int unsigned CSR_CTRL_CLEAR = 4;  // Asynchronous clear level
   localparam logic [4:0]  CSR_CTRL_RST   = 5'h00;

   // ----------------------------------------------------------------
   // Command register fields (write-only pulses)
   // ----------------------------------------------------------------
   localparam int unsigned CSR_CMD_SHIFT = 0;
   localparam int unsigned CSR_CMD_LOAD  = 1;
   localparam int unsigned CSR_CMD_RESET = 2;

   // ----------------------------------------------------------------
   // Information register fields
   // ----------------------------------------------------------------
   localparam int unsigned CSR_INFO_WIDTH = 0;  // Five bits wide
   localparam int unsigned CSR_INFO_SYNC  = 8;
   localparam int unsigned CSR_INFO_LOAD  = 9;
   localparam int unsigned CSR_INFO_BIDIR = 10;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] CSR_DATA_RST  = 16'h0000;
   localparam logic        CSR_STAGE_RST = 1'b0;
   localparam logic [31:0] CSR_RD_ZERO   = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic {
      CSR_ASYNC_CLEAR,
      CSR_SYNC_RESET
   } csr_rst_style_t;

   typedef enum logic [2:0] {
      CSR_OP_HOLD,
      CSR_OP_ZERO,
      CSR_OP_LOAD,
      CSR_OP_UP,
      CSR_OP_DOWN
   } csr_op_t;

endpackage : csr_pkg

`default_nettype wire

// file: csr_shift_assertions.sv
// Port checker for the shift register and its Wishbone slave.
// Assumes it is bound to csr_shift_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module csr_shift_assertions
#(
   parameter int unsigned WIDTH = 8
)
(
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             async_clear_i,
   input wire logic             load_i,
   input wire logic             clk_en_i,
   input wire logic             shift_left_i,
   input wire logic             left_serial_in_i,
   input wire logic             right_serial_in_i,
   input wire logic [WIDTH-1:0] data_i,
   input wire logic [WIDTH-1:0] q_o,
   input wire logic             cascade_o,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [7:0]       wb_adr_i,
   input wire logic [3:0]       wb_sel_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic             wb_ack_o
);
   logic sw_reg;
   // Software mode, followed from acknowledged control writes
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         sw_reg <= 1'b0;
      else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
               && wb_adr_i == 8'h00)
         sw_reg <= wb_dat_i[0];
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_quiet;
      !sw_reg && !async_clear_i;
   endsequence
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   AST_CLEAR: assert property (
      async_clear_i && !sw_reg |-> q_o == '0 && !cascade_o)
      else $error("clear did not zero the stages");
   AST_HOLD: assert property (
      s_quiet ##0 (!load_i && !clk_en_i) ##1 s_quiet |-> $stable(q_o))
      else $error("stages moved without load or enable");
   AST_LOAD: assert property (
      s_quiet ##0 load_i ##1 s_quiet |-> q_o == $past(data_i))
      else $error("parallel load wrong");
   AST_UP: assert property (
      s_quiet ##0 (!load_i && clk_en_i && shift_left_i) ##1 s_quiet
      |-> q_o == {$past(q_o[WIDTH-2:0]), $past(left_serial_in_i)})
      else $error("up shift wrong");
   AST_DOWN: assert property (
      s_quiet ##0 (!load_i && clk_en_i && !shift_left_i) ##1 s_quiet
      |-> q_o == {$past(right_serial_in_i), $past(q_o[WIDTH-1:1])})
      else $error("down shift wrong");
   AST_GRST: assert property (
      disable iff (1'b0) rst_i |-> q_o == '0 && !wb_ack_o)
      else $error("global reset did not clear");
   AST_CASCADE: assert property (
      cascade_o == q_o[WIDTH-1])
      else $error("cascade output differs from top stage");
   AST_ACK: assert property (
      s_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not a one cycle pulse after request");
endmodule : csr_shift_assertions
`default_nettype wire

// file: csr_shift_top.sv
// Configurable shift register of 4, 8 or 16 stages with a Wishbone
// register port. Assumes user logic drives the control pins
// synchronously to clk_i, a glitch-free clear pin, and a classic
// single-cycle Wishbone master.

`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Width is 4, 8 or 16 stages; outputs indexed from stage zero upward.
// - Asynchronous-clear variant: high clear zeroes all stages at once, overriding everything.
// - Loadable variants: enable and load both low leave every stage unchanged.
// - Load high, clear inactive: each edge copies parallel data, enable ignored.
// - Bidirectional: shift only when enabled, load and reset low; direction input steers.
// - Direction high: stage zero takes left serial input, others take lower neighbour.
// - Direction low: top stage takes right serial input, others take upper neighbour.
// - Synchronous-reset variants: reset high at an edge clears all, above everything.
// - Synchronous-reset loadable: load high, reset low loads parallel data.
// - Serial-only synchronous: enabled edge shifts left serial input into stage zero upward.
// - Serial-only synchronous: edges with enable low change nothing.
// - At power-up every stage starts cleared low, without a clock.
// - Global reset clears every stage low, like the power-on state.
module csr_shift_top
#(
   parameter int unsigned             WIDTH     = 8,
   parameter csr_pkg::csr_rst_style_t RST_STYLE = csr_pkg::CSR_ASYNC_CLEAR,
   parameter bit                      HAS_LOAD  = 1'b1,
   parameter bit                      HAS_BIDIR = 1'b1
)
(
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // User-side controls and data
   input  wire logic                      async_clear_i,
   input  wire logic                      sync_reset_i,
   input  wire logic                      load_i,
   input  wire logic                      clk_en_i,
   input  wire logic                      shift_left_i,
   input  wire logic                      left_serial_in_i,
   input  wire logic                      right_serial_in_i,
   input  wire logic [WIDTH-1:0]          data_i,
   output logic      [WIDTH-1:0]          q_o,
   output logic                           cascade_o,
   // Wishbone slave
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [csr_pkg::CSR_ADR_W-1:0] wb_adr_i,
   input  wire logic [csr_pkg::CSR_SEL_W-1:0] wb_sel_i,
   input  wire logic [csr_pkg::CSR_DAT_W-1:0] wb_dat_i,
   output logic      [csr_pkg::CSR_DAT_W-1:0] wb_dat_o,
   output logic                           wb_ack_o
);

   // ----------------------------------------------------------------
   // Derived constants
   // ----------------------------------------------------------------
   // Zero padding above the stages in bus read data
   localparam int unsigned PAD_W = csr_pkg::CSR_DAT_W - WIDTH;

   // Build-time description read back by software
   localparam logic [4:0] INFO_WIDTH = 5'(WIDTH);
   localparam logic       INFO_SYNC  =
      (RST_STYLE == csr_pkg::CSR_SYNC_RESET);
   localparam logic       INFO_LOAD  = HAS_LOAD;
   localparam logic       INFO_BIDIR = HAS_BIDIR;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                              bus_req;
   logic                              wr_take;
   logic                              hit_ctrl;
   logic                              hit_data;
   logic                              hit_cmd;
   logic                              hit_stat;
   logic                              hit_info;
   logic [csr_pkg::CSR_CTRL_W-1:0]    ctrl_reg;
   logic [csr_pkg::CSR_MAX_W-1:0]     data_reg;
   logic                              cmd_shift_reg;
   logic                              cmd_load_reg;
   logic                              cmd_reset_reg;
   logic [csr_pkg::CSR_DAT_W-1:0]     rd_next;
   logic                              sw_mode;
   logic                              eff_clear;
   logic                              eff_reset;
   logic                              eff_load;
   logic                              eff_en;
   logic                              eff_left;
   logic                              eff_sli;
   logic                              eff_sri;
   logic [WIDTH-1:0]                  eff_data;
   logic                              stage_clr;
   csr_pkg::csr_op_t                  op;
   logic [WIDTH-1:0]                  stage_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Word-aligned address match for each register
   assign bus_req  = wb_cyc_i & wb_stb_i;
   assign hit_ctrl = (wb_adr_i == csr_pkg::CSR_OFF_CTRL);
   assign hit_data = (wb_adr_i == csr_pkg::CSR_OFF_DATA);
   assign hit_cmd  = (wb_adr_i == csr_pkg::CSR_OFF_CMD);
   assign hit_stat = (wb_adr_i == csr_pkg::CSR_OFF_STAT);
   assign hit_info = (wb_adr_i == csr_pkg::CSR_OFF_INFO);

   // Writes land on the edge where the master sees ack
   assign wr_take  = bus_req & wb_we_i & wb_ack_o;

   // ----------------------------------------------------------------
   // Acknowledge
   // ----------------------------------------------------------------
   // One wait state, ack held for exactly one cycle
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= bus_req & ~wb_ack_o;
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Byte lane 0 holds every control field
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ctrl_reg <= csr_pkg::CSR_CTRL_RST;
      else if (wr_take && hit_ctrl && wb_sel_i[0])
         ctrl_reg <= wb_dat_i[csr_pkg::CSR_CTRL_W-1:0];
   end

   // ----------------------------------------------------------------
   // Parallel data register
   // ----------------------------------------------------------------
   // Two byte lanes, each written under its own select
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         data_reg <= csr_pkg::CSR_DATA_RST;
      else if (wr_take && hit_data)
      begin
         if (wb_sel_i[0])
            data_reg[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1])
            data_reg[15:8] <= wb_dat_i[15:8];
      end
   end

   // ----------------------------------------------------------------
   // Command pulses
   // ----------------------------------------------------------------
   // A command write gives a single-cycle strobe to the stages
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cmd_shift_reg <= 1'b0;
         cmd_load_reg  <= 1'b0;
         cmd_reset_reg <= 1'b0;
      end
      else
      begin
         cmd_shift_reg <= wr_take & hit_cmd & wb_sel_i[0]
                          & wb_dat_i[csr_pkg::CSR_CMD_SHIFT];
         cmd_load_reg  <= wr_take & hit_cmd & wb_sel_i[0]
                          & wb_dat_i[csr_pkg::CSR_CMD_LOAD];
         cmd_reset_reg <= wr_take & hit_cmd & wb_sel_i[0]
                          & wb_dat_i[csr_pkg::CSR_CMD_RESET];
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Unmapped and write-only offsets read as zero
   always_comb
   begin
      rd_next = csr_pkg::CSR_RD_ZERO;
      if (hit_ctrl)
         rd_next[csr_pkg::CSR_CTRL_W-1:0] = ctrl_reg;
      else if (hit_data)
         rd_next[csr_pkg::CSR_MAX_W-1:0] = data_reg;
      else if (hit_stat)
         rd_next = {{PAD_W{1'b0}}, stage_q};
      else if (hit_info)
      begin
         rd_next[csr_pkg::CSR_INFO_WIDTH +: 5] = INFO_WIDTH;
         rd_next[csr_pkg::CSR_INFO_SYNC]       = INFO_SYNC;
         rd_next[csr_pkg::CSR_INFO_LOAD]       = INFO_LOAD;
         rd_next[csr_pkg::CSR_INFO_BIDIR]      = INFO_BIDIR;
      end
   end

   // Read data captured with the request, valid beside ack
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         wb_dat_o <= csr_pkg::CSR_RD_ZERO;
      else if (bus_req && !wb_ack_o && !wb_we_i)
         wb_dat_o <= rd_next;
   end

   // ----------------------------------------------------------------
   // Control source selection
   // ----------------------------------------------------------------
   // Software mode replaces every user pin by register fields
   assign sw_mode = ctrl_reg[csr_pkg::CSR_CTRL_SW];

   always_comb
   begin
      if (sw_mode)
      begin
         eff_clear = ctrl_reg[csr_pkg::CSR_CTRL_CLEAR];
         eff_reset = cmd_reset_reg;
         eff_load  = cmd_load_reg;
         eff_en    = cmd_shift_reg;
         eff_left  = ctrl_reg[csr_pkg::CSR_CTRL_LEFT];
         eff_sli   = ctrl_reg[csr_pkg::CSR_CTRL_SLI];
         eff_sri   = ctrl_reg[csr_pkg::CSR_CTRL_SRI];
         eff_data  = data_reg[WIDTH-1:0];
      end
      else
      begin
         eff_clear = async_clear_i;
         eff_reset = sync_reset_i;
         eff_load  = load_i;
         eff_en    = clk_en_i;
         eff_left  = shift_left_i;
         eff_sli   = left_serial_in_i;
         eff_sri   = right_serial_in_i;
         eff_data  = data_i;
      end
   end

   // ----------------------------------------------------------------
   // Stage clear
   // ----------------------------------------------------------------
   // Global reset always clears; user clear only in the async variant
   assign stage_clr = rst_i
                    | ((RST_STYLE == csr_pkg::CSR_ASYNC_CLEAR)
                       & eff_clear);

   // ----------------------------------------------------------------
   // Operation decode
   // ----------------------------------------------------------------
   csr_op_sel
   #(
      .RST_STYLE (RST_STYLE),
      .HAS_LOAD  (HAS_LOAD),
      .HAS_BIDIR (HAS_BIDIR)
   )
   u_op_sel
   (
      .sync_reset_i (eff_reset),
      .load_i       (eff_load),
      .clk_en_i     (eff_en),
      .shift_left_i (eff_left),
      .op_o         (op)
   );

   // ----------------------------------------------------------------
   // Stage chain
   // ----------------------------------------------------------------
   // Neighbour wiring; the ends take the serial inputs
   for (genvar n = 0; n < WIDTH; n++)
   begin : g_stage
      logic lower;
      logic upper;

      if (n == 0)
      begin : g_first
         assign lower = eff_sli;
      end
      else
      begin : g_mid_lo
         assign lower = stage_q[n-1];
      end

      if (n == WIDTH-1)
      begin : g_last
         assign upper = eff_sri;
      end
      else
      begin : g_mid_hi
         assign upper = stage_q[n+1];
      end

      csr_stage u_stage
      (
         .clk_i        (clk_i),
         .clr_i        (stage_clr),
         .op_i         (op),
         .d_i          (eff_data[n]),
         .from_lower_i (lower),
         .from_upper_i (upper),
         .q_o          (stage_q[n])
      );
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Parallel outputs straight from the stage flip-flops
   assign q_o       = stage_q;
   // Top stage feeds the next instance's left serial input
   assign cascade_o = stage_q[WIDTH-1];

endmodule : csr_shift_top

`default_nettype wire

// file: csr_stage.sv
// One stage of the shift register: a flip-flop with a five-way input.
// Assumes the operation code is decoded once for all stages.

`timescale 1ns/1ps
`default_nettype none

module csr_stage
(
   input  wire logic            clk_i,
   input  wire logic            clr_i,
   input  wire csr_pkg::csr_op_t op_i,
   input  wire logic            d_i,
   input  wire logic            from_lower_i,
   input  wire logic            from_upper_i,
   output var  logic            q_o
);

   // ----------------------------------------------------------------
   // Stage flip-flop
   // ----------------------------------------------------------------
   // Clear acts at once, without a clock edge
   always_ff @(posedge clk_i or posedge clr_i)
   begin
      if (clr_i)
         q_o <= csr_pkg::CSR_STAGE_RST;
      else
      begin
         unique case (op_i)
            csr_pkg::CSR_OP_HOLD: q_o <= q_o;
            csr_pkg::CSR_OP_ZERO: q_o <= csr_pkg::CSR_STAGE_RST;
            csr_pkg::CSR_OP_LOAD: q_o <= d_i;
            csr_pkg::CSR_OP_UP:   q_o <= from_lower_i;
            csr_pkg::CSR_OP_DOWN: q_o <= from_upper_i;
            default:              q_o <= q_o;            // Illegal code
         endcase
      end
   end

endmodule : csr_stage

`default_nettype wire

// file: csr_user_cascade.sv
// Behavioural next register of a cascade, fed from the block's top stage.
// Assumes it shares clock, clear, load and enable with the block.
`timescale 1ns/1ps
`default_nettype none
module csr_user_cascade
#(
   parameter int unsigned W = 8
)
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         clear_i,
   input  wire logic         ld_i,
   input  wire logic         en_i,
   input  wire logic         up_i,
   input  wire logic         cascade_i,
   output logic     [W-1:0] q_o
);
   // Second stage: loads zeros, shifts the top output in on up shifts
   always_ff @(posedge clk_i or posedge rst_i or posedge clear_i)
   begin
      if (rst_i || clear_i)
         q_o <= '0;
      else if (ld_i)
         q_o <= '0;
      else if (en_i && up_i)
         q_o <= {q_o[W-2:0], cascade_i};
      else if (en_i)
         q_o <= {1'b0, q_o[W-1:1]};
   end
endmodule : csr_user_cascade
`default_nettype wire
